// >>> design/cfd_fault_diag.sv
/*
 * Ten-channel load fault diagnosis with filtering, overload latch-off and
 * an APB register port with a level interrupt.
 * Assumes sense inputs and control inputs synchronous to clk.
 */
`timescale 1ns/1ns
`include "cfd_cfg.svh"

module cfd_fault_diag #(
	parameter logic [`CFD_CNT_W-1:0] EXT_SHORT_CYC = `CFD_CNT_W'(`CFD_TD_EXT_SHORT_CYC),
	parameter logic [`CFD_CNT_W-1:0] EXT_LONG_CYC = `CFD_CNT_W'(`CFD_TD_EXT_LONG_CYC)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB
	input wire cfd_pkg::cfd_apb_req_t apb_req,
	output cfd_pkg::cfd_apb_rsp_t apb_rsp,
	// Channel control and sense
	input wire logic [`CFD_NCH-1:0] par_in,
	input wire cfd_pkg::cfd_sense_t sense,
	// Outputs
	output logic [`CFD_NCH-1:0] gate_on,
	output logic irq
);

	localparam int N = `CFD_NCH;

	logic [N-1:0] off_diag_enable_bit, next_off_diag_enable_bit;
	logic blind_time_extend_bit, next_blind_time_extend_bit;
	logic blind_time_long_bit, next_blind_time_long_bit;
	logic [N-1:0] serial_on, next_serial_on;
	logic [N-1:0] irq_status, next_irq_status;
	logic [N-1:0] irq_enable, next_irq_enable;
	logic [N-1:0] next_gate_on;
	logic next_irq;
	logic [N-1:0] diag_clear_command, next_diag_clear_command;
	cfd_pkg::cfd_apb_rsp_t next_apb_rsp;

	logic [N-1:0] filt_store, latched, stored, oct_evt;
	cfd_pkg::cfd_code_t filt_code [N];
	cfd_pkg::cfd_code_t channel_diag_code [N];
	logic [2*N-1:0] diag_word;

	logic setup, access_wr;
	logic [31:0] rd_mux;
	logic mapped;

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_ch
			cfd_chan_filter #(
				.EXT_CAPABLE(g >= `CFD_EXT_FIRST),
				.EXT_SHORT(EXT_SHORT_CYC),
				.EXT_LONG(EXT_LONG_CYC)
			) u_filter (
				.clk(clk),
				.sys_rst(sys_rst),
				.short_to_ground_fault(sense.short_to_ground_fault[g]),
				.ol(sense.ol[g]),
				.diag_en(off_diag_enable_bit[g] & ~gate_on[g]),
				.ext_bit(blind_time_extend_bit),
				.long_bit(blind_time_long_bit),
				.restart(diag_clear_command[g]),
				.store_code(filt_code[g]),
				.store(filt_store[g])
			);
			cfd_diag_store u_store (
				.clk(clk),
				.sys_rst(sys_rst),
				.filt_store(filt_store[g]),
				.filt_code(filt_code[g]),
				.oct_evt(oct_evt[g]),
				.clear(diag_clear_command[g]),
				.code(channel_diag_code[g]),
				.latched(latched[g]),
				.stored(stored[g])
			);
			assign oct_evt[g] = sense.overcurrent_overtemp_fault[g] & gate_on[g] & ~latched[g];
			assign diag_word[2*g+1:2*g] = channel_diag_code[g];
		end
	endgenerate

	// ----------------------------------------
	// Output stage and interrupt
	// ----------------------------------------
	always_comb begin
		next_gate_on = (par_in | serial_on) & ~latched & ~oct_evt;
		next_irq = |(irq_status & irq_enable);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gate_on <= '0;
			irq <= 1'b0;
		end else begin
			gate_on <= next_gate_on;
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// APB register port
	// ----------------------------------------
	always_comb begin
		setup = apb_req.psel & ~apb_req.penable & ~apb_rsp.pready;
		access_wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
		mapped = 1'b1;
		rd_mux = 32'h0;
		case (apb_req.paddr)
			`CFD_OFF_DIAG: rd_mux = {{(32-2*N){1'b0}}, diag_word};
			`CFD_OFF_SETTINGS: begin
				rd_mux[N-1:0] = off_diag_enable_bit;
				rd_mux[`CFD_SET_EXTEND_POS] = blind_time_extend_bit;
				rd_mux[`CFD_SET_LONG_POS] = blind_time_long_bit;
			end
			`CFD_OFF_SERIAL_ON: rd_mux[N-1:0] = serial_on;
			`CFD_OFF_DIAG_CLEAR: rd_mux = 32'h0;
			`CFD_OFF_IRQ_STATUS: rd_mux[N-1:0] = irq_status;
			`CFD_OFF_IRQ_CLEAR: rd_mux = 32'h0;
			`CFD_OFF_IRQ_ENABLE: rd_mux[N-1:0] = irq_enable;
			`CFD_OFF_OUT_STATE: rd_mux[N-1:0] = gate_on;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_apb_rsp = apb_rsp;
		next_apb_rsp.pready = setup;
		if (setup) begin
			next_apb_rsp.pslverr = ~mapped;
			next_apb_rsp.prdata = apb_req.pwrite ? 32'h0 : rd_mux;
		end
		next_off_diag_enable_bit = off_diag_enable_bit;
		next_blind_time_extend_bit = blind_time_extend_bit;
		next_blind_time_long_bit = blind_time_long_bit;
		next_serial_on = serial_on;
		next_irq_enable = irq_enable;
		next_diag_clear_command = '0;
		next_irq_status = irq_status;
		if (access_wr) begin
			case (apb_req.paddr)
				`CFD_OFF_SETTINGS: begin
					next_off_diag_enable_bit = apb_req.pwdata[N-1:0];
					next_blind_time_extend_bit = apb_req.pwdata[`CFD_SET_EXTEND_POS];
					next_blind_time_long_bit = apb_req.pwdata[`CFD_SET_LONG_POS];
				end
				`CFD_OFF_SERIAL_ON: next_serial_on = apb_req.pwdata[N-1:0];
				`CFD_OFF_DIAG_CLEAR: next_diag_clear_command = apb_req.pwdata[N-1:0];
				`CFD_OFF_IRQ_CLEAR: next_irq_status = irq_status & ~apb_req.pwdata[N-1:0];
				`CFD_OFF_IRQ_ENABLE: next_irq_enable = apb_req.pwdata[N-1:0];
				default: next_irq_enable = irq_enable;
			endcase
		end
		// Set wins over a clear in the same cycle
		next_irq_status = next_irq_status | stored;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			apb_rsp <= '0;
			off_diag_enable_bit <= `CFD_RST_OFF_DIAG_EN;
			blind_time_extend_bit <= 1'b0;
			blind_time_long_bit <= 1'b0;
			serial_on <= `CFD_RST_SERIAL_ON;
			irq_enable <= `CFD_RST_IRQ_ENABLE;
			irq_status <= '0;
			diag_clear_command <= '0;
		end else begin
			apb_rsp <= next_apb_rsp;
			off_diag_enable_bit <= next_off_diag_enable_bit;
			blind_time_extend_bit <= next_blind_time_extend_bit;
			blind_time_long_bit <= next_blind_time_long_bit;
			serial_on <= next_serial_on;
			irq_enable <= next_irq_enable;
			irq_status <= next_irq_status;
			diag_clear_command <= next_diag_clear_command;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking

	chk_oct_gate_off: assert property (disable iff (sys_rst) |oct_evt |=> (gate_on & $past(oct_evt)) == '0)
		else $error("overload channel not switched off");
	chk_latched_off: assert property (disable iff (sys_rst) |latched |=> (gate_on & $past(latched)) == '0)
		else $error("latched channel switched on");
	chk_reset_state: assert property (sys_rst |=> diag_word == {(2*N){1'b1}} && !blind_time_extend_bit)
		else $error("reset state wrong");
	chk_clear_release: assert property (disable iff (sys_rst)
		access_wr && apb_req.paddr == `CFD_OFF_DIAG_CLEAR && apb_req.pwdata[0] && !oct_evt[0]
		##1 !filt_store[0] && !oct_evt[0] |=> !latched[0])
		else $error("clear did not release channel");
	chk_irq_sticky: assert property (disable iff (sys_rst) |stored |=> (irq_status & $past(stored)) == $past(stored))
		else $error("event lost from status");

endmodule

// >>> common/cfd_cfg.svh
/*
 * Constants of the channel fault diagnosis filter: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 20 MHz core clock and a 32-bit APB register port.
 */
`ifndef CFD_CFG_SVH
`define CFD_CFG_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define CFD_NCH 10
`define CFD_EXT_FIRST 6
`define CFD_CNT_W 17

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFD_OFF_DIAG 8'h00
`define CFD_OFF_SETTINGS 8'h04
`define CFD_OFF_SERIAL_ON 8'h08
`define CFD_OFF_DIAG_CLEAR 8'h0c
`define CFD_OFF_IRQ_STATUS 8'h10
`define CFD_OFF_IRQ_CLEAR 8'h14
`define CFD_OFF_IRQ_ENABLE 8'h18
`define CFD_OFF_OUT_STATE 8'h1c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CFD_SET_EXTEND_POS 16
`define CFD_SET_LONG_POS 17
`define CFD_RST_OFF_DIAG_EN 10'h3ff
`define CFD_RST_SERIAL_ON 10'h000
`define CFD_RST_IRQ_ENABLE 10'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CFD_CLK_NS 50
`define CFD_TD_STD_NS 100000
`define CFD_TD_EXT_SHORT_NS 1650000
`define CFD_TD_EXT_LONG_NS 3300000
`define CFD_TD_STD_CYC ((`CFD_TD_STD_NS + `CFD_CLK_NS - 1) / `CFD_CLK_NS)
`define CFD_TD_EXT_SHORT_CYC ((`CFD_TD_EXT_SHORT_NS + `CFD_CLK_NS - 1) / `CFD_CLK_NS)
`define CFD_TD_EXT_LONG_CYC ((`CFD_TD_EXT_LONG_NS + `CFD_CLK_NS - 1) / `CFD_CLK_NS)

`endif

// >>> common/cfd_pkg.sv
/*
 * Types of the channel fault diagnosis filter.
 * Assumes cfd_cfg.svh for the channel count.
 */
`include "cfd_cfg.svh"

package cfd_pkg;

	// Two-bit diagnosis code per channel
	typedef enum logic [1:0] {
		CFD_CODE_SCG = 2'h0,
		CFD_CODE_OL = 2'h1,
		CFD_CODE_OCT = 2'h2,
		CFD_CODE_OK = 2'h3
	} cfd_code_t;

	typedef enum logic [1:0] {
		CFD_F_IDLE,
		CFD_F_RUN,
		CFD_F_DONE
	} cfd_filt_state_t;

	// Analog comparator outputs, one bit per channel
	typedef struct packed {
		logic [`CFD_NCH-1:0] short_to_ground_fault;
		logic [`CFD_NCH-1:0] ol;
		logic [`CFD_NCH-1:0] overcurrent_overtemp_fault;
	} cfd_sense_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cfd_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cfd_apb_rsp_t;

endpackage

// >>> design/cfd_chan_filter.sv
/*
 * Off-state diagnosis filter of one channel.
 * Assumes comparator inputs synchronous to clk; restart comes from a clear.
 */
`timescale 1ns/1ns
`include "cfd_cfg.svh"

module cfd_chan_filter #(
	parameter bit EXT_CAPABLE = 1'b0,
	parameter logic [`CFD_CNT_W-1:0] EXT_SHORT = `CFD_CNT_W'(`CFD_TD_EXT_SHORT_CYC),
	parameter logic [`CFD_CNT_W-1:0] EXT_LONG = `CFD_CNT_W'(`CFD_TD_EXT_LONG_CYC)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Conditions
	input wire logic short_to_ground_fault,
	input wire logic ol,
	input wire logic diag_en,
	input wire logic ext_bit,
	input wire logic long_bit,
	input wire logic restart,
	// Result
	output cfd_pkg::cfd_code_t store_code,
	output logic store
);

	localparam logic [`CFD_CNT_W-1:0] STD_LIM = `CFD_CNT_W'(`CFD_TD_STD_CYC);

	cfd_pkg::cfd_filt_state_t state, next_state;
	logic [`CFD_CNT_W-1:0] cnt, next_cnt, lim;
	cfd_pkg::cfd_code_t next_code;
	logic next_store, cond;
	cfd_pkg::cfd_code_t latest;

	// ----------------------------------------
	// Delay selection
	// ----------------------------------------
	always_comb begin
		if (EXT_CAPABLE && ext_bit) begin
			lim = long_bit ? EXT_LONG : EXT_SHORT;
		end else begin
			lim = STD_LIM;
		end
	end

	// ----------------------------------------
	// Filter sequence
	// ----------------------------------------
	always_comb begin
		cond = diag_en & (short_to_ground_fault | ol);
		latest = short_to_ground_fault ? cfd_pkg::CFD_CODE_SCG : cfd_pkg::CFD_CODE_OL;
		next_state = state;
		next_cnt = cnt;
		next_code = store_code;
		next_store = 1'b0;
		if (restart) begin
			next_state = cfd_pkg::CFD_F_IDLE;
			next_cnt = '0;
		end else begin
			case (state)
				cfd_pkg::CFD_F_IDLE: begin
					next_cnt = '0;
					if (cond) begin
						next_state = cfd_pkg::CFD_F_RUN;
						next_code = latest;
					end
				end
				cfd_pkg::CFD_F_RUN: begin
					if (!cond) begin
						next_state = cfd_pkg::CFD_F_IDLE;
					end else begin
						// Change between the two conditions keeps the timer
						next_code = latest;
						if (cnt >= lim - `CFD_CNT_W'(1)) begin
							next_store = 1'b1;
							next_state = cfd_pkg::CFD_F_DONE;
						end else begin
							next_cnt = cnt + `CFD_CNT_W'(1);
						end
					end
				end
				cfd_pkg::CFD_F_DONE: begin
					if (!cond) begin
						next_state = cfd_pkg::CFD_F_IDLE;
					end
				end
				default: begin
					next_state = cfd_pkg::CFD_F_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= cfd_pkg::CFD_F_IDLE;
			cnt <= '0;
			store_code <= cfd_pkg::CFD_CODE_OK;
			store <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			store_code <= next_code;
			store <= next_store;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_filter_delay: assert property (next_store |-> cnt == lim - `CFD_CNT_W'(1))
		else $error("filter stored before its delay");
	chk_filter_disabled: assert property (!diag_en && !restart |=> state == cfd_pkg::CFD_F_IDLE && !store)
		else $error("filter ran with diagnosis disabled");
	chk_filter_latest: assert property (state == cfd_pkg::CFD_F_RUN && cond && !restart
		|=> store_code == $past(latest))
		else $error("filter did not keep latest condition");

endmodule

// >>> design/cfd_diag_store.sv
/*
 * Diagnosis code storage and overload latch of one channel.
 * Assumes oct_evt is already qualified by an active gate.
 */
`timescale 1ns/1ns
`include "cfd_cfg.svh"

module cfd_diag_store (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Events
	input wire logic filt_store,
	input wire cfd_pkg::cfd_code_t filt_code,
	input wire logic oct_evt,
	input wire logic clear,
	// State
	output cfd_pkg::cfd_code_t code,
	output logic latched,
	output logic stored
);

	cfd_pkg::cfd_code_t next_code;
	logic next_latched, next_stored, pend, next_pend;

	// ----------------------------------------
	// Code update
	// ----------------------------------------
	always_comb begin
		next_code = code;
		next_latched = latched;
		next_pend = pend;
		next_stored = 1'b0;
		if (clear) begin
			next_code = cfd_pkg::CFD_CODE_OK;
			next_latched = 1'b0;
			next_pend = 1'b0;
		end
		if (filt_store) begin
			next_code = filt_code;
			next_stored = 1'b1;
			if (oct_evt) begin
				// Overload during a write is held and stored after it
				next_pend = 1'b1;
				next_latched = 1'b1;
			end
		end else if (oct_evt || (pend && !clear)) begin
			next_code = cfd_pkg::CFD_CODE_OCT;
			next_latched = 1'b1;
			next_pend = 1'b0;
			next_stored = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			code <= cfd_pkg::CFD_CODE_OK;
			latched <= 1'b0;
			pend <= 1'b0;
			stored <= 1'b0;
		end else begin
			code <= next_code;
			latched <= next_latched;
			pend <= next_pend;
			stored <= next_stored;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_collide;
		filt_store && oct_evt;
	endsequence
	sequence s_late_oct;
		##1 latched ##1 code == cfd_pkg::CFD_CODE_OCT && latched;
	endsequence

	chk_oct_code: assert property (oct_evt && !filt_store |=> code == cfd_pkg::CFD_CODE_OCT && latched)
		else $error("overload not stored");
	chk_pend_store: assert property (s_collide ##1 !filt_store |=> code == cfd_pkg::CFD_CODE_OCT)
		else $error("overload during write lost");
	chk_pend_order: assert property (s_collide |-> s_late_oct)
		else $error("overload not latched after collision");
	chk_overwrite: assert property (filt_store |=> code == $past(filt_code))
		else $error("new diagnosis did not overwrite");
	chk_clear_code: assert property (clear && !filt_store && !oct_evt && !pend
		|=> code == cfd_pkg::CFD_CODE_OK && !latched)
		else $error("clear did not restore no fault");
	chk_latch_hold: assert property (latched && !clear |=> latched)
		else $error("overload latch released without clear");

endmodule

// >>> verification/cfd_host_model.sv
/*
 * Host side model: APB master with the overload confirmation procedure.
 * Assumes the register map of cfd_fault_diag and a free running clk.
 */
`timescale 1ns/1ns

module cfd_host_model #(
	parameter int ON_HOLD_CYC = 40,
	parameter int OFF_HOLD_CYC = 4400
) (
	// Clock
	input wire logic clk,
	// APB
	output cfd_pkg::cfd_apb_req_t apb_req,
	input wire cfd_pkg::cfd_apb_rsp_t apb_rsp
);
	cfd_pkg::cfd_apb_rsp_t rsp_seen;

	initial apb_req = '0;

	// Settled answer, as it will be sampled at the next rising edge
	always @(negedge clk) begin
		rsp_seen = apb_rsp;
	end

	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		// Only the bench watchdog ends a wait for ready
		do begin
			@(posedge clk);
		end while (rsp_seen.pready !== 1'b1);
		rdata = rsp_seen.prdata;
		err = rsp_seen.pslverr;
		apb_req <= '0;
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
		logic [31:0] d;
		logic e;
		xfer(1'b1, addr, wdata, d, e);
	endtask

	task automatic rd(input logic [7:0] addr, output logic [31:0] d, output logic e);
		xfer(1'b0, addr, 32'h0, d, e);
	endtask

	// Open-load confirmation: switch off, wait out the standard filter delay, reread
	task automatic confirm_open_load(input int ch, output logic [1:0] code);
		logic [31:0] d;
		logic e;
		rd(8'h08, d, e);
		wr(8'h08, d & ~(32'h1 << ch));
		repeat (OFF_HOLD_CYC) @(posedge clk);
		rd(8'h00, d, e);
		code = d[2*ch +: 2];
	endtask

	// Overload confirmation: disable, clear, switch on, reread, re-enable
	task automatic confirm_overload(input int ch, output logic [1:0] code);
		logic [31:0] d;
		logic e;
		rd(8'h04, d, e);
		wr(8'h04, d & ~(32'h1 << ch));
		wr(8'h0c, 32'h1 << ch);
		wr(8'h08, 32'h1 << ch);
		repeat (ON_HOLD_CYC) @(posedge clk);
		rd(8'h00, d, e);
		code = d[2*ch +: 2];
		rd(8'h04, d, e);
		wr(8'h04, d | (32'h1 << ch));
	endtask
endmodule

// >>> verification/tb_channel_fault_diagnosis_filter.sv
/*
 * Self-checking bench of cfd_fault_diag with the host model on APB.
 * Assumes shortened extended delays of 40 and 80 cycles.
 */
`timescale 1ns/1ns

module tb_channel_fault_diagnosis_filter;
	typedef struct {int ch; logic ol; logic [1:0] bt; int lim; logic [1:0] code;} cfd_row_t;
	localparam int STD = 2000;
	localparam int ESH = 40;
	localparam int ELG = 80;

	logic clk;
	logic sys_rst;
	cfd_pkg::cfd_apb_req_t apb_req;
	cfd_pkg::cfd_apb_rsp_t apb_rsp;
	logic [9:0] par_in;
	cfd_pkg::cfd_sense_t sense;
	logic [9:0] gate_on;
	logic irq;
	int n_mismatch = 0;
	int n_compared = 0;
	logic [31:0] d;
	logic e;
	logic [1:0] code;
	cfd_row_t rows[6] = '{'{0, 1'b0, 2'h0, STD, 2'h0}, '{1, 1'b1, 2'h0, STD, 2'h1},
		'{5, 1'b1, 2'h1, STD, 2'h1}, '{6, 1'b1, 2'h1, ESH, 2'h1},
		'{7, 1'b1, 2'h2, STD, 2'h1}, '{9, 1'b0, 2'h3, ELG, 2'h0}};

	cfd_fault_diag #(.EXT_SHORT_CYC(17'(ESH)), .EXT_LONG_CYC(17'(ELG))) dut (
		.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.par_in(par_in), .sense(sense), .gate_on(gate_on), .irq(irq));

	cfd_host_model #(.ON_HOLD_CYC(40)) host (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic code_of(input int ch, output logic [1:0] c);
		host.rd(8'h00, d, e);
		c = d[2*ch +: 2];
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		par_in = '0;
		sense = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		host.rd(8'h00, d, e);
		check(d, 32'h000fffff);
		host.rd(8'h04, d, e);
		check(d, 32'h000003ff);
		host.rd(8'h20, d, e);
		check(32'(e), 32'h1);
		check(d, 32'h0);
		check({22'h0, gate_on}, 32'h0);
		$display("reset test done");
		// Off periods are kept just longer than the filter delay selected for each row
		// Extended blind time applies only to channels 6-9 and only with the extend bit set
		foreach (rows[i]) begin
			host.wr(8'h04, {14'h0, rows[i].bt, 6'h0, 10'h3ff});
			if (rows[i].ol) sense.ol[rows[i].ch] <= 1'b1;
			else sense.short_to_ground_fault[rows[i].ch] <= 1'b1;
			repeat (rows[i].lim - 8) @(posedge clk);
			code_of(rows[i].ch, code);
			check(32'(code), 32'h3);
			repeat (12) @(posedge clk);
			code_of(rows[i].ch, code);
			check(32'(code), 32'(rows[i].code));
			sense <= '0;
			host.wr(8'h0c, 32'h1 << rows[i].ch);
			repeat (2) @(posedge clk);
			host.rd(8'h00, d, e);
			check(d, 32'h000fffff);
			$display("row %0d done", i);
		end
		// Swap keeps the timer, then a new entry overwrites
		host.wr(8'h04, 32'h3ff);
		host.wr(8'h14, 32'h3ff);
		host.wr(8'h18, 32'h4);
		sense.short_to_ground_fault[2] <= 1'b1;
		repeat (1000) @(posedge clk);
		sense.short_to_ground_fault[2] <= 1'b0;
		sense.ol[2] <= 1'b1;
		repeat (990) @(posedge clk);
		code_of(2, code);
		check(32'(code), 32'h3);
		repeat (15) @(posedge clk);
		code_of(2, code);
		check(32'(code), 32'h1);
		check(32'(irq), 32'h1);
		sense <= '0;
		@(posedge clk);
		sense.short_to_ground_fault[2] <= 1'b1;
		repeat (STD + 15) @(posedge clk);
		code_of(2, code);
		check(32'(code), 32'h0);
		host.wr(8'h18, 32'h0);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0);
		host.wr(8'h18, 32'h4);
		host.wr(8'h14, 32'h4);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0);
		host.rd(8'h10, d, e);
		check(32'(d[2]), 32'h0);
		sense <= '0;
		host.wr(8'h0c, 32'h4);
		$display("swap test done");
		// Overload latch-off and confirmation
		par_in[3] <= 1'b1;
		repeat (3) @(posedge clk);
		check(32'(gate_on[3]), 32'h1);
		sense.overcurrent_overtemp_fault[3] <= 1'b1;
		repeat (3) @(posedge clk);
		check(32'(gate_on[3]), 32'h0);
		sense.overcurrent_overtemp_fault[3] <= 1'b0;
		code_of(3, code);
		check(32'(code), 32'h2);
		repeat (20) @(posedge clk);
		check(32'(gate_on[3]), 32'h0);
		host.confirm_overload(3, code);
		check(32'(code), 32'h3);
		check(32'(gate_on[3]), 32'h1);
		host.rd(8'h1c, d, e);
		check(d, 32'h00000008);
		par_in <= '0;
		host.wr(8'h08, 32'h0);
		$display("overload test done");
		// Off-state diagnosis disabled per channel
		host.wr(8'h04, 32'h3ef);
		sense.ol[4] <= 1'b1;
		repeat (STD + 100) @(posedge clk);
		code_of(4, code);
		check(32'(code), 32'h3);
		host.wr(8'h04, 32'h3ff);
		repeat (STD + 15) @(posedge clk);
		code_of(4, code);
		check(32'(code), 32'h1);
		host.confirm_open_load(4, code);
		check(32'(code), 32'h1);
		$display("enable test done");
		// Mid-run reset returns settings, codes and status to reset values
		host.wr(8'h04, 32'h000303ff);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		host.rd(8'h04, d, e);
		check(d, 32'h000003ff);
		host.rd(8'h00, d, e);
		check(d, 32'h000fffff);
		host.rd(8'h10, d, e);
		check(d, 32'h0);
		$display("mid-run reset test done");
		close_out();
	end
endmodule
